/* panel_display_model.sv */
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Panel or monitor on the far side: counts frames and sync pulses
module panel_display_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        vsync_i,
	input  wire logic        frame_start_i,
	output logic      [15:0] vsync_cnt_o,
	output logic      [15:0] frame_cnt_o
);
	logic vsync_q;

	// A display locks on the sync edge, not on the level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			vsync_q     <= 1'b0;
			vsync_cnt_o <= 16'h0000;
			frame_cnt_o <= 16'h0000;
		end else begin
			vsync_q <= vsync_i;
			if (vsync_i && !vsync_q)
				vsync_cnt_o <= vsync_cnt_o + 16'h0001;
			if (frame_start_i)
				frame_cnt_o <= frame_cnt_o + 16'h0001;
		end
	end
endmodule : panel_display_model

`default_nettype wire

/* panel_vtiming.sv */
// Overview of operation
// - Cursor blink period in vsyncs is (field+1)*2, half on; resets to 3.
// - Graphics pixel blink is fixed: 32 vsyncs, 16 on and 16 off.
// - Character duty field 00..11 gives 50%, 25%, 50%, 75%; default 10.
// - Char period equals cursor period for 00, otherwise twice it.
// - Mapping on in panel text bypasses lookup and palette, else normal.
// - Mapped 4-bit pixels expand to 6 bits, out3 per mono/colour select.
// - Mapping enable has no effect on CRT or on panel graphics.
// - Close but unequal fg/bg colours are separated by the shift values.
// - Saturation bit: 0 clamps to 0..15, 1 wraps modulo 16.
// - Foreground shift added when fg above bg, subtracted when below.
// - Background shift added when bg above fg, subtracted when below.
// - Legacy enhancement swaps attributes 07h and 0Fh in panel text.
// - New enhancement resets to 1, no CRT effect; never both bits set (the logic does not block both, each acts).
// - Graphics polarity inverts CRT and panel graphics; text only panel.
// - Mono 1-bit panels: video at or above threshold gives 1, else 0.
// - Alternate vertical total is 10 bits; lines per frame = value + 2.
// - Overflow holds bit 8 of total/size/start in 0..2, bit 9 in 5..7.
// - Panel vsync asserts at scan line sync start value plus 1.
// - Vsync ends when low four line bits match the four-bit end field.
// - Vertical panel size is 10 bits; panel lines = value + 1.
// - Supply select bit captures its strap at reset release; 1 = 5V.
// - Polynomial frc N and M fields give row and column offsets.
`include "panel_vtiming_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module panel_vtiming
	import panel_vtiming_pkg::*;
(
	input  wire logic       CLK_SYS_I,
	input  wire logic       RST_I,
	input  wire logic [7:0] IO_INDEX_I,
	input  wire logic [7:0] IO_WDATA_I,
	input  wire logic       IO_WR_I,
	input  wire logic       IO_RD_I,
	output logic      [7:0] IO_RDATA_O,
	input  wire logic       STRAP_SUPPLY_I,
	input  wire logic       VSYNC_TICK_I,
	input  wire logic       LINE_TICK_I,
	input  wire logic       PANEL_MODE_I,
	input  wire logic       TEXT_MODE_I,
	input  wire logic       MONO_COLOR_SEL_I,
	input  wire logic       PALETTE_EN_I,
	input  wire logic       MONO_1BPP_I,
	input  wire logic       POLY_FRC_SEL_I,
	input  wire logic       PIX_VALID_I,
	input  wire logic       PIX_ON_I,
	input  wire logic [3:0] PIX_FG_I,
	input  wire logic [3:0] PIX_BG_I,
	input  wire logic [5:0] PIX_GFX_I,
	input  wire logic [7:0] PIX_ATTR_I,
	output logic            CURSOR_BLINK_O,
	output logic            CHAR_BLINK_O,
	output logic            GFX_BLINK_O,
	output logic            PIX_VALID_O,
	output logic      [5:0] PIX_DATA_O,
	output logic      [3:0] FG_O,
	output logic      [3:0] BG_O,
	output logic      [7:0] ATTR_O,
	output logic            USE_LUT_O,
	output logic            USE_PALETTE_O,
	output logic            MONO_BIT_O,
	output logic            TEXT_ENH_NEW_O,
	output logic            PANEL_VSYNC_O,
	output logic            PANEL_ACTIVE_O,
	output logic            FRAME_START_O,
	output logic      [9:0] LINE_O,
	output logic      [3:0] FRC_ROW_OFS_O,
	output logic      [3:0] FRC_COL_OFS_O,
	output logic            SUPPLY_5V_O
);

	// =================================================================
	// Helpers
	function automatic color4_t shift4(input color4_t a, input color4_t s,
		input logic sub, input logic wrap);
		logic [4:0] r;
		// Carry or borrow into bit 4 means the limit was crossed
		r = sub ? ({1'b0, a} - {1'b0, s}) : ({1'b0, a} + {1'b0, s});
		if (wrap || !r[4])
			shift4 = r[3:0];
		else
			shift4 = sub ? 4'h0 : 4'hf;
	endfunction : shift4

	function automatic color6_t expand6(input color4_t c, input logic mono);
		logic b3;
		b3 = mono ? |c : c[3];
		expand6 = {c[3], c[3], b3, c[2:0]};
	endfunction : expand6

	// =================================================================
	// Register file
	logic [7:0] blink_q, cmap_q, shift_q, cmapc_q, vt_q, ovf_q;
	logic [7:0] vss_q, vse_q, psize_q, drive_q, frc_q, fb_q;
	logic       strap_pend_q;
	logic       wr_blink;

	assign wr_blink = IO_WR_I && (IO_INDEX_I == `IDX_BLINK_RATE);

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			blink_q <= `RST_BLINK_RATE;
			cmap_q  <= `RST_ZERO;
			shift_q <= `RST_ZERO;
			cmapc_q <= `RST_COLOR_MAP;
			vt_q    <= `RST_ZERO;
			ovf_q   <= `RST_ZERO;
			vss_q   <= `RST_ZERO;
			vse_q   <= `RST_ZERO;
			psize_q <= `RST_ZERO;
			frc_q   <= `RST_ZERO;
			fb_q    <= `RST_ZERO;
		end else if (IO_WR_I) begin
			unique case (IO_INDEX_I)
				`IDX_BLINK_RATE:   blink_q <= IO_WDATA_I;
				`IDX_CMAP_CTRL:    cmap_q  <= IO_WDATA_I;
				`IDX_CMAP_SHIFT:   shift_q <= IO_WDATA_I;
				`IDX_COLOR_MAP:    cmapc_q <= IO_WDATA_I;
				`IDX_ALT_VTOTAL:   vt_q    <= IO_WDATA_I;
				`IDX_ALT_VOVF:     ovf_q   <= IO_WDATA_I;
				`IDX_ALT_VS_START: vss_q   <= IO_WDATA_I;
				`IDX_ALT_VS_END:   vse_q   <= IO_WDATA_I;
				`IDX_VPANEL_SIZE:  psize_q <= IO_WDATA_I;
				`IDX_POLY_FRC:     frc_q   <= IO_WDATA_I;
				`IDX_FB_CTRL:      fb_q    <= IO_WDATA_I;
				default: ;
			endcase
		end
	end

	// Strap is caught by a clocked process on the first edge after release
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			drive_q      <= `RST_ZERO;
			strap_pend_q <= 1'b1;
		end else if (strap_pend_q) begin
			drive_q[`DRV_SUPPLY_BIT] <= STRAP_SUPPLY_I;
			strap_pend_q             <= 1'b0;
		end else if (IO_WR_I && IO_INDEX_I == `IDX_DRIVE_CTRL) begin
			drive_q <= IO_WDATA_I;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			IO_RDATA_O <= `RST_ZERO;
		end else if (IO_RD_I) begin
			unique case (IO_INDEX_I)
				`IDX_BLINK_RATE:   IO_RDATA_O <= blink_q;
				`IDX_CMAP_CTRL:    IO_RDATA_O <= cmap_q;
				`IDX_CMAP_SHIFT:   IO_RDATA_O <= shift_q;
				`IDX_COLOR_MAP:    IO_RDATA_O <= cmapc_q;
				`IDX_ALT_VTOTAL:   IO_RDATA_O <= vt_q;
				`IDX_ALT_VOVF:     IO_RDATA_O <= ovf_q;
				`IDX_ALT_VS_START: IO_RDATA_O <= vss_q;
				`IDX_ALT_VS_END:   IO_RDATA_O <= vse_q;
				`IDX_VPANEL_SIZE:  IO_RDATA_O <= psize_q;
				`IDX_DRIVE_CTRL:   IO_RDATA_O <= drive_q;
				`IDX_POLY_FRC:     IO_RDATA_O <= frc_q;
				`IDX_FB_CTRL:      IO_RDATA_O <= fb_q;
				default:           IO_RDATA_O <= `RST_ZERO;
			endcase
		end
	end

	// =================================================================
	// Blink timing
	logic [8:0] cur_half, cur_last, chr_last, chr_on;
	logic [8:0] cur_cnt_q, chr_cnt_q;
	logic [4:0] gfx_cnt_q;
	char_duty_t duty;

	assign duty     = char_duty_t'(blink_q[7:6]);
	assign cur_half = {3'b000, blink_q[5:0]} + 9'd1;
	assign cur_last = {cur_half[7:0], 1'b0} - 9'd1;
	// Char period doubles for every duty setting but the first
	assign chr_last = (duty == DUTY_HALF_A) ? cur_last
		: {cur_half[6:0], 2'b00} - 9'd1;

	always_comb begin
		unique case (duty)
			DUTY_HALF_A:  chr_on = cur_half;
			DUTY_QUARTER: chr_on = cur_half;
			DUTY_HALF_B:  chr_on = {cur_half[7:0], 1'b0};
			DUTY_THREE_Q: chr_on = {cur_half[7:0], 1'b0} + cur_half;
		endcase
	end

	// A rate write restarts all phases so a new period starts clean
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			cur_cnt_q <= 9'h000;
			chr_cnt_q <= 9'h000;
			gfx_cnt_q <= 5'h00;
		end else if (wr_blink) begin
			cur_cnt_q <= 9'h000;
			chr_cnt_q <= 9'h000;
			gfx_cnt_q <= 5'h00;
		end else if (VSYNC_TICK_I) begin
			cur_cnt_q <= (cur_cnt_q >= cur_last) ? 9'h000
				: cur_cnt_q + 9'd1;
			chr_cnt_q <= (chr_cnt_q >= chr_last) ? 9'h000
				: chr_cnt_q + 9'd1;
			gfx_cnt_q <= gfx_cnt_q + 5'd1;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			CURSOR_BLINK_O <= 1'b0;
			CHAR_BLINK_O   <= 1'b0;
			GFX_BLINK_O    <= 1'b0;
		end else begin
			CURSOR_BLINK_O <= cur_cnt_q < cur_half;
			CHAR_BLINK_O   <= chr_cnt_q < chr_on;
			GFX_BLINK_O    <= gfx_cnt_q < `GFX_BLINK_HALF;
		end
	end

	// =================================================================
	// Text contrast mapping and video path
	logic    panel_text, mapped, close, gfx_inv, txt_inv, inv;
	color4_t fg_adj, bg_adj, diff, sel_col;
	color6_t video;
	logic [7:0] attr;

	assign panel_text = PANEL_MODE_I && TEXT_MODE_I;
	assign mapped  = panel_text && cmap_q[`CMAP_EN_BIT];
	assign diff    = (PIX_FG_I > PIX_BG_I) ? PIX_FG_I - PIX_BG_I
		: PIX_BG_I - PIX_FG_I;
	// Equal colours are left alone, so an all-blank cell stays blank
	assign close   = (PIX_FG_I != PIX_BG_I) && (diff < cmap_q[4:1]);
	assign fg_adj  = close ? shift4(PIX_FG_I, shift_q[3:0],
		PIX_FG_I < PIX_BG_I, cmap_q[`CMAP_SAT_BIT]) : PIX_FG_I;
	assign bg_adj  = close ? shift4(PIX_BG_I, shift_q[7:4],
		PIX_BG_I < PIX_FG_I, cmap_q[`CMAP_SAT_BIT]) : PIX_BG_I;
	assign sel_col = PIX_ON_I ? (mapped ? fg_adj : PIX_FG_I)
		: (mapped ? bg_adj : PIX_BG_I);
	assign gfx_inv = !TEXT_MODE_I && cmapc_q[`CMAP_GVP_BIT];
	assign txt_inv = panel_text && cmap_q[`CMAP_TVP_BIT];
	assign inv     = gfx_inv || txt_inv;

	always_comb begin
		if (!TEXT_MODE_I)
			video = PIX_GFX_I;
		else if (mapped)
			video = expand6(sel_col, MONO_COLOR_SEL_I);
		else
			video = {2'b00, sel_col};
		if (inv)
			video = ~video;
	end

	always_comb begin
		attr = PIX_ATTR_I;
		if (panel_text && cmap_q[`CMAP_LEGACY_BIT]) begin
			if (PIX_ATTR_I == `ATTR_NORMAL)
				attr = `ATTR_BRIGHT;
			else if (PIX_ATTR_I == `ATTR_BRIGHT)
				attr = `ATTR_NORMAL;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			PIX_VALID_O   <= 1'b0;
			PIX_DATA_O    <= 6'h00;
			FG_O          <= 4'h0;
			BG_O          <= 4'h0;
			ATTR_O        <= 8'h00;
			USE_LUT_O     <= 1'b1;
			USE_PALETTE_O <= 1'b0;
			MONO_BIT_O    <= 1'b0;
		end else begin
			PIX_VALID_O <= PIX_VALID_I;
			if (PIX_VALID_I) begin
				PIX_DATA_O    <= video;
				FG_O          <= mapped ? fg_adj : PIX_FG_I;
				BG_O          <= mapped ? bg_adj : PIX_BG_I;
				ATTR_O        <= attr;
				USE_LUT_O     <= !mapped;
				USE_PALETTE_O <= !mapped && PALETTE_EN_I;
				MONO_BIT_O    <= PANEL_MODE_I && MONO_1BPP_I
					&& (video >= cmapc_q[5:0]);
			end
		end
	end

	// =================================================================
	// Panel vertical timing
	logic [10:0] vt_last, vs_line, ps_last;
	line_t       line_q;

	assign vt_last = {1'b0, ovf_q[`OVF_VT9_BIT], ovf_q[`OVF_VT8_BIT], vt_q}
		+ 11'd1;
	assign vs_line = {1'b0, ovf_q[`OVF_VS9_BIT], ovf_q[`OVF_VS8_BIT], vss_q}
		+ 11'd1;
	assign ps_last = {1'b0, ovf_q[`OVF_PS9_BIT], ovf_q[`OVF_PS8_BIT],
		psize_q};

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			line_q        <= 10'h000;
			FRAME_START_O <= 1'b0;
		end else begin
			FRAME_START_O <= 1'b0;
			if (LINE_TICK_I) begin
				if ({1'b0, line_q} >= vt_last) begin
					line_q        <= 10'h000;
					FRAME_START_O <= 1'b1;
				end else begin
					line_q <= line_q + 10'd1;
				end
			end
		end
	end

	// Sync is judged on the line just entered so start and end track it
	line_t line_nx;
	assign line_nx = ({1'b0, line_q} >= vt_last) ? 10'h000
		: line_q + 10'd1;

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			PANEL_VSYNC_O  <= 1'b0;
			PANEL_ACTIVE_O <= 1'b0;
			LINE_O         <= 10'h000;
		end else if (LINE_TICK_I) begin
			LINE_O         <= line_nx;
			PANEL_ACTIVE_O <= {1'b0, line_nx} <= ps_last;
			if ({1'b0, line_nx} == vs_line)
				PANEL_VSYNC_O <= 1'b1;
			else if (line_nx[3:0] == vse_q[3:0])
				PANEL_VSYNC_O <= 1'b0;
		end
	end

	// =================================================================
	// Static control outputs
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			TEXT_ENH_NEW_O <= 1'b0;
			FRC_ROW_OFS_O  <= 4'h0;
			FRC_COL_OFS_O  <= 4'h0;
			SUPPLY_5V_O    <= 1'b1;
		end else begin
			TEXT_ENH_NEW_O <= panel_text && cmapc_q[`CMAP_NEWTE_BIT];
			FRC_ROW_OFS_O  <= (PANEL_MODE_I && POLY_FRC_SEL_I)
				? frc_q[3:0] : 4'h0;
			FRC_COL_OFS_O  <= (PANEL_MODE_I && POLY_FRC_SEL_I)
				? frc_q[7:4] : 4'h0;
			SUPPLY_5V_O    <= drive_q[`DRV_SUPPLY_BIT];
		end
	end

	// =================================================================
	// Checks
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);

	a_blink_restart: assert property (
		wr_blink |=> cur_cnt_q == 9'h000 && chr_cnt_q == 9'h000
			&& gfx_cnt_q == 5'h00)
		else $error("blink counters not restarted by rate write");

	a_gfx_blink_wrap: assert property (
		VSYNC_TICK_I && !wr_blink && gfx_cnt_q == `GFX_BLINK_PERIOD
			|=> gfx_cnt_q == 5'h00 ##1 GFX_BLINK_O)
		else $error("graphics blink period is not 32 vsyncs");

	a_cursor_phase: assert property (
		VSYNC_TICK_I && !wr_blink && cur_cnt_q == cur_last
			|=> cur_cnt_q == 9'h000 ##1 CURSOR_BLINK_O)
		else $error("cursor blink period wrong");

	a_char_default: assert property (
		VSYNC_TICK_I && !wr_blink && chr_cnt_q == chr_last
			|=> chr_cnt_q == 9'h000 ##1 CHAR_BLINK_O)
		else $error("char blink period wrong");

	a_path_bypass: assert property (
		PIX_VALID_I && mapped |=> !USE_LUT_O && !USE_PALETTE_O)
		else $error("mapped text did not bypass lookup");

	a_crt_lookup: assert property (
		PIX_VALID_I && !PANEL_MODE_I |=> USE_LUT_O
			&& USE_PALETTE_O == $past(PALETTE_EN_I))
		else $error("crt path lost lookup table");

	a_clamp_high: assert property (
		PIX_VALID_I && mapped && close && !cmap_q[`CMAP_SAT_BIT]
			&& PIX_FG_I > PIX_BG_I |=> FG_O >= $past(PIX_FG_I))
		else $error("foreground clamp wrapped");

	a_legacy_swap: assert property (
		PIX_VALID_I && panel_text && cmap_q[`CMAP_LEGACY_BIT]
			&& PIX_ATTR_I == `ATTR_NORMAL |=> ATTR_O == `ATTR_BRIGHT)
		else $error("attribute 07h not swapped");

	a_vsync_start: assert property (
		LINE_TICK_I && {1'b0, line_nx} == vs_line |=> PANEL_VSYNC_O)
		else $error("panel vsync not asserted at start line");

	a_frame_wrap: assert property (
		LINE_TICK_I && {1'b0, line_q} == vt_last |=> line_q == 10'h000
			&& FRAME_START_O)
		else $error("frame did not wrap at total plus 2");

	a_strap_catch: assert property (
		strap_pend_q |=> drive_q[`DRV_SUPPLY_BIT] == $past(STRAP_SUPPLY_I)
			##1 SUPPLY_5V_O == $past(STRAP_SUPPLY_I, 2))
		else $error("supply strap not captured");

endmodule : panel_vtiming

`default_nettype wire

/* panel_vtiming_cfg.svh */
`ifndef PANEL_VTIMING_CFG_SVH
`define PANEL_VTIMING_CFG_SVH

// =====================================================================
// Register indices on the indexed I/O port
`define IDX_BLINK_RATE    8'h60
`define IDX_CMAP_CTRL     8'h61
`define IDX_CMAP_SHIFT    8'h62
`define IDX_COLOR_MAP     8'h63
`define IDX_ALT_VTOTAL    8'h64
`define IDX_ALT_VOVF      8'h65
`define IDX_ALT_VS_START  8'h66
`define IDX_ALT_VS_END    8'h67
`define IDX_VPANEL_SIZE   8'h68
`define IDX_DRIVE_CTRL    8'h6c
`define IDX_POLY_FRC      8'h6e
`define IDX_FB_CTRL       8'h6f

// =====================================================================
// Reset values
`define RST_BLINK_RATE    8'h83
`define RST_COLOR_MAP     8'h40
`define RST_ZERO          8'h00

// =====================================================================
// Field positions
`define CMAP_EN_BIT       0
`define CMAP_SAT_BIT      5
`define CMAP_LEGACY_BIT   6
`define CMAP_TVP_BIT      7
`define CMAP_NEWTE_BIT    6
`define CMAP_GVP_BIT      7
`define OVF_VT8_BIT       0
`define OVF_PS8_BIT       1
`define OVF_VS8_BIT       2
`define OVF_VT9_BIT       5
`define OVF_PS9_BIT       6
`define OVF_VS9_BIT       7
`define DRV_SUPPLY_BIT    1

// =====================================================================
// Timing counts, in vertical syncs, and the text attribute codes
`define GFX_BLINK_PERIOD  5'd31
`define GFX_BLINK_HALF    5'd16
`define ATTR_NORMAL       8'h07
`define ATTR_BRIGHT       8'h0f

`endif

/* panel_vtiming_pkg.sv */
package panel_vtiming_pkg;
	typedef logic [3:0] color4_t;
	typedef logic [5:0] color6_t;
	typedef logic [9:0] line_t;
	typedef enum logic [1:0] {
		DUTY_HALF_A,
		DUTY_QUARTER,
		DUTY_HALF_B,
		DUTY_THREE_Q
	} char_duty_t;
endpackage : panel_vtiming_pkg

/* panel_vtiming_test.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module panel_vtiming_test;
	import panel_vtiming_pkg::*;

	logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, strap = 1'b1;
	logic [7:0] idx = 8'h00, wdat = 8'h00, attr = 8'h00, rdat;
	logic       vtk = 1'b0, ltk = 1'b0, panel = 1'b1, text = 1'b1;
	logic       mono = 1'b0, pal = 1'b1, m1 = 1'b0, poly = 1'b0;
	logic       pv = 1'b0, pon = 1'b1;
	color4_t    fg = 4'h0, bg = 4'h0, fgo, bgo, rofs, cofs;
	color6_t    gfx = 6'h00, pdat;
	logic [7:0] attro;
	line_t      line;
	logic       cb, chb, gb, pvo, lut, palo, mbit, enh, vs, act, fs, s5;
	logic [15:0] vcnt, fcnt;
	int         error_cnt = 0, checks = 0;

	initial forever #2.5 clk = ~clk;

	panel_vtiming dut_u (.CLK_SYS_I(clk), .RST_I(rst), .IO_INDEX_I(idx),
		.IO_WDATA_I(wdat), .IO_WR_I(wr), .IO_RD_I(rd), .IO_RDATA_O(rdat),
		.STRAP_SUPPLY_I(strap), .VSYNC_TICK_I(vtk), .LINE_TICK_I(ltk),
		.PANEL_MODE_I(panel), .TEXT_MODE_I(text), .MONO_COLOR_SEL_I(mono),
		.PALETTE_EN_I(pal), .MONO_1BPP_I(m1), .POLY_FRC_SEL_I(poly),
		.PIX_VALID_I(pv), .PIX_ON_I(pon), .PIX_FG_I(fg), .PIX_BG_I(bg),
		.PIX_GFX_I(gfx), .PIX_ATTR_I(attr), .CURSOR_BLINK_O(cb),
		.CHAR_BLINK_O(chb), .GFX_BLINK_O(gb), .PIX_VALID_O(pvo),
		.PIX_DATA_O(pdat), .FG_O(fgo), .BG_O(bgo), .ATTR_O(attro),
		.USE_LUT_O(lut), .USE_PALETTE_O(palo), .MONO_BIT_O(mbit),
		.TEXT_ENH_NEW_O(enh), .PANEL_VSYNC_O(vs), .PANEL_ACTIVE_O(act),
		.FRAME_START_O(fs), .LINE_O(line), .FRC_ROW_OFS_O(rofs),
		.FRC_COL_OFS_O(cofs), .SUPPLY_5V_O(s5));

	panel_display_model disp_u (.clk_i(clk), .rst_i(rst), .vsync_i(vs),
		.frame_start_i(fs), .vsync_cnt_o(vcnt), .frame_cnt_o(fcnt));

	// =====================================================================
	// Shared cycles
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1; idx <= i; wdat <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] i, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1; idx <= i;
		@(posedge clk);
		rd <= 1'b0;
		settle(1);
		d = rdat;
	endtask : rd_reg

	task automatic pixel(input logic o, input color4_t f, input color4_t b,
			input logic [7:0] a, input color6_t g);
		@(posedge clk);
		pv <= 1'b1; pon <= o; fg <= f; bg <= b; attr <= a; gfx <= g;
		@(posedge clk);
		pv <= 1'b0;
		settle(1);
	endtask : pixel

	function automatic color6_t expand(input color4_t c, input logic m);
		return {c[3], c[3], m ? |c : c[3], c[2:0]};
	endfunction : expand

	// =====================================================================
	// Scenarios
	task automatic t_regs();
		logic [7:0] d;
		rd_reg(8'h60, d); `CHK(d, 8'h83)
		rd_reg(8'h63, d); `CHK(d, 8'h40)
		rd_reg(8'h6c, d); `CHK(d, 8'h02)
		`CHK(s5, 1'b1)
		wr_reg(8'h70, 8'h5a);
		rd_reg(8'h70, d); `CHK(d, 8'h00)
		wr_reg(8'h65, 8'he7);
		rd_reg(8'h65, d); `CHK(d, 8'he7)
	endtask : t_regs

	task automatic t_blink();
		int per, on;
		for (int d = 0; d < 4; d++) begin
			per = (d == 0) ? 4 : 8;
			on = (d < 2) ? 2 : (d == 2) ? 4 : 6;
			wr_reg(8'h60, {d[1:0], 6'd1});
			settle(2);
			for (int k = 0; k < 32; k++) begin
				`CHK(cb, logic'((k % 4) < 2))
				`CHK(chb, logic'((k % per) < on))
				`CHK(gb, logic'((k % 32) < 16))
				@(posedge clk);
				vtk <= 1'b1;
				@(posedge clk);
				vtk <= 1'b0;
				settle(2);
			end
		end
	endtask : t_blink

	task automatic t_map();
		logic [23:0] tb [8] = '{24'h540073, 24'hed00fc, 24'hfd101c,
			24'h120003, 24'h660066, 24'h940094, 24'h0211e3, 24'h540173};
		logic [23:0] c;
		panel <= 1'b1; text <= 1'b1;
		wr_reg(8'h62, 8'h12);
		for (int i = 0; i < 8; i++) begin
			c = tb[i];
			mono <= c[8];
			wr_reg(8'h61, {c[7], 1'b0, c[12], 4'h4, 1'b1});
			pixel(!c[4], c[23:20], c[19:16], 8'h07, 6'h00);
			`CHK(fgo, c[7:4])
			`CHK(bgo, c[3:0])
			`CHK(pdat, expand(c[4] ? c[3:0] : c[7:4], c[8]) ^ {6{c[7]}})
			`CHK({lut, palo, attro}, {2'b00, 8'h07})
			`CHK(enh, 1'b1)
		end
	endtask : t_map

	task automatic t_text();
		logic [7:0] ai [3] = '{8'h07, 8'h0f, 8'h12};
		logic [7:0] ao [3] = '{8'h0f, 8'h07, 8'h12};
		wr_reg(8'h63, 8'h00);
		wr_reg(8'h61, 8'h41);
		for (int i = 0; i < 3; i++) begin
			pixel(1'b1, 4'h1, 4'h2, ai[i], 6'h00);
			`CHK(attro, ao[i])
		end
		`CHK(enh, 1'b0)
		panel <= 1'b0;
		pixel(1'b1, 4'h1, 4'h2, 8'h07, 6'h00);
		`CHK({attro, lut, palo, enh}, {8'h07, 3'b110})
		@(posedge clk);
		pv <= 1'b1;
		@(posedge clk);
		pv <= 1'b0;
		#1;
		`CHK(pvo, 1'b1)
	endtask : t_text

	task automatic t_gfx();
		logic [15:0] tb [4] = '{16'h8d54, 16'h8f00, 16'h2101, 16'h1f00};
		text <= 1'b0; pal <= 1'b0; m1 <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			panel <= tb[i][8];
			wr_reg(8'h63, {tb[i][15], 7'h20});
			pixel(1'b1, 4'h0, 4'h0, 8'h00, tb[i][13:8] ^ {6{tb[i][15]}});
			`CHK(pdat, tb[i][13:8])
			`CHK(mbit, tb[i][0])
			`CHK({lut, palo}, 2'b10)
		end
		panel <= 1'b1;
	endtask : t_gfx

	task automatic t_vert();
		line_t ln = 10'd0;
		logic  v = 1'b0;
		logic [15:0] v0, f0;
		wr_reg(8'h64, 8'h02);
		wr_reg(8'h65, 8'h01);
		wr_reg(8'h66, 8'h05);
		wr_reg(8'h67, 8'h09);
		wr_reg(8'h68, 8'hfa);
		settle(1);
		v0 = vcnt; f0 = fcnt;
		for (int k = 0; k < 520; k++) begin
			@(posedge clk);
			ltk <= 1'b1;
			@(posedge clk);
			ltk <= 1'b0;
			settle(2);
			ln = (ln == 10'h103) ? 10'd0 : ln + 10'd1;
			if (ln == 10'd6) v = 1'b1;
			else if (ln[3:0] == 4'h9) v = 1'b0;
			`CHK(line, ln)
			`CHK(vs, v)
			`CHK(act, logic'(ln <= 10'd250))
		end
		`CHK(fcnt - f0, 16'd2)
		`CHK(vcnt - v0, 16'd2)
	endtask : t_vert

	task automatic t_frc();
		wr_reg(8'h6e, 8'ha5);
		settle(2);
		`CHK({rofs, cofs}, 8'h00)
		poly <= 1'b1;
		settle(3);
		`CHK({rofs, cofs}, 8'h5a)
	endtask : t_frc

	task automatic t_strap();
		logic [7:0] d;
		@(posedge clk);
		rst <= 1'b1; strap <= 1'b0;
		settle(3);
		rst <= 1'b0;
		settle(3);
		rd_reg(8'h6c, d); `CHK(d, 8'h00)
		`CHK(s5, 1'b0)
		wr_reg(8'h6c, 8'h02);
		settle(2);
		`CHK(s5, 1'b1)
	endtask : t_strap

	// =====================================================================
	// Verdict
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	// Whole run is about 2.8k cycles, so this limit only trips on a hang
	initial begin
		#200us;
		error_cnt++;
		finish_test();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		settle(2);
		t_regs();
		t_blink();
		t_map();
		t_text();
		t_gfx();
		t_vert();
		t_frc();
		t_strap();
		finish_test();
	end
endmodule : panel_vtiming_test

`default_nettype wire
